//--- rtl/msi_pkg.sv
// Operation
// - bit 4 shows inverted clear-to-send
// - bit 0 flags clear-to-send change since read
// - clear-to-send never gates the transmitter
// - clear-to-send change plus enable raises interrupt
// - bit 7 shows inverted carrier-detect
// - bit 3 flags carrier-detect change since read
// - carrier-detect change plus enable raises interrupt
// - separate status and pins per channel
// - bit 5 shows inverted data-set-ready
// - bit 1 flags data-set-ready change, interrupts
package msi_pkg;
  // byte addresses, channel 0 then channel 1
  localparam logic [3:0] STATUS0_ADDR = 4'h0;
  localparam logic [3:0] ENABLE0_ADDR = 4'h4;
  localparam logic [3:0] STATUS1_ADDR = 4'h8;
  localparam logic [3:0] ENABLE1_ADDR = 4'hC;
  // status field positions
  localparam int CTS_CHG_BIT = 0;
  localparam int DSR_CHG_BIT = 1;
  localparam int DCD_CHG_BIT = 3;
  localparam int CTS_BIT     = 4;
  localparam int DSR_BIT     = 5;
  localparam int DCD_BIT     = 7;
  // enable register field
  localparam int MS_IRQ_EN_BIT = 0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [2:0] PIN_RESET    = 3'h7;
endpackage : msi_pkg

//--- rtl/msi_channel.sv
`timescale 1ns/1ns
// one serial channel's modem status logic
module msi_channel (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] pins_n,
  input  wire logic       read_status,
  input  wire logic       irq_en,
  output logic      [7:0] status,
  output logic            irq
);
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] last;
    logic [2:0] changed;
  } msi_chan_type;

  msi_chan_type cur;
  msi_chan_type next_cur;

  // pins order: {dcd, dsr, cts}; sync then edge detect on second stage
  always_comb begin
    next_cur       = cur;
    next_cur.sync1 = pins_n;
    next_cur.sync2 = cur.sync1;
    next_cur.last  = cur.sync2;
    // read clears, but a change in the same cycle wins
    if (read_status) begin
      next_cur.changed = 3'h0;
    end
    next_cur.changed = next_cur.changed | (cur.sync2 ^ cur.last);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '{msi_pkg::PIN_RESET, msi_pkg::PIN_RESET, msi_pkg::PIN_RESET, 3'h0};
    end else begin
      cur <= next_cur;
    end
  end

  // status image, reserved bits read zero
  always_comb begin
    status                        = 8'h00;
    status[msi_pkg::CTS_CHG_BIT]  = cur.changed[0];
    status[msi_pkg::DSR_CHG_BIT]  = cur.changed[1];
    status[msi_pkg::DCD_CHG_BIT]  = cur.changed[2];
    status[msi_pkg::CTS_BIT]      = ~cur.last[0];
    status[msi_pkg::DSR_BIT]      = ~cur.last[1];
    status[msi_pkg::DCD_BIT]      = ~cur.last[2];
  end

  assign irq = irq_en & (|cur.changed);
endmodule : msi_channel

//--- rtl/msi_top.sv
`timescale 1ns/1ns
// modem status inputs for two serial channels, classic wishbone slave
module msi_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        first_cts_n,
  input  wire logic        first_dsr_n,
  input  wire logic        first_dcd_n,
  input  wire logic        ir_cts_n,
  input  wire logic        ir_dsr_n,
  input  wire logic        ir_dcd_n,
  output logic             first_irq,
  output logic             ir_irq
);
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  en0;
    logic [7:0]  en1;
  } msi_top_type;

  msi_top_type cur;
  msi_top_type next_cur;
  logic [7:0]  stat0;
  logic [7:0]  stat1;
  logic        req;
  logic        rd0;
  logic        rd1;

  // one wait state: ack in the cycle after the request is seen
  assign req = wb_cyc_i & wb_stb_i & ~cur.ack;
  // clear flags only on the accepted read, when ack goes out
  assign rd0 = req & ~wb_we_i & (wb_adr_i == msi_pkg::STATUS0_ADDR);
  assign rd1 = req & ~wb_we_i & (wb_adr_i == msi_pkg::STATUS1_ADDR);

  // each channel owns its own pins and status image
  msi_channel u_first (
    .clk         (clk),
    .rst         (rst),
    .pins_n      ({first_dcd_n, first_dsr_n, first_cts_n}),
    .read_status (rd0),
    .irq_en      (cur.en0[msi_pkg::MS_IRQ_EN_BIT]),
    .status      (stat0),
    .irq         (first_irq)
  );

  msi_channel u_ir (
    .clk         (clk),
    .rst         (rst),
    .pins_n      ({ir_dcd_n, ir_dsr_n, ir_cts_n}),
    .read_status (rd1),
    .irq_en      (cur.en1[msi_pkg::MS_IRQ_EN_BIT]),
    .status      (stat1),
    .irq         (ir_irq)
  );

  // bus decode; unmapped reads return zero, writes ignored
  always_comb begin
    next_cur     = cur;
    next_cur.ack = req;
    if (req) begin
      next_cur.dat = 32'h0000_0000;
      if (wb_we_i) begin
        if (wb_adr_i == msi_pkg::ENABLE0_ADDR && wb_sel_i[0]) begin
          next_cur.en0 = wb_dat_i[7:0];
        end
        if (wb_adr_i == msi_pkg::ENABLE1_ADDR && wb_sel_i[0]) begin
          next_cur.en1 = wb_dat_i[7:0];
        end
      end else begin
        case (wb_adr_i)
          msi_pkg::STATUS0_ADDR: next_cur.dat = {24'h000000, stat0};
          msi_pkg::ENABLE0_ADDR: next_cur.dat = {24'h000000, cur.en0};
          msi_pkg::STATUS1_ADDR: next_cur.dat = {24'h000000, stat1};
          msi_pkg::ENABLE1_ADDR: next_cur.dat = {24'h000000, cur.en1};
          default:               next_cur.dat = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '{1'b0, 32'h0000_0000, msi_pkg::ENABLE_RESET, msi_pkg::ENABLE_RESET};
    end else begin
      cur <= next_cur;
    end
  end

  // no transmitter here; clear-to-send is status only and gates nothing
  assign wb_ack_o = cur.ack;
  assign wb_dat_o = cur.dat;
endmodule : msi_top

//--- tb/msi_monitor.sv
`timescale 1ns/1ns
module msi_monitor (
  input wire logic clk,rst,wb_cyc_i,wb_stb_i,wb_we_i,wb_ack_o,first_irq,ir_irq,
  input wire logic [3:0] wb_adr_i,wb_sel_i,
  input wire logic [31:0] wb_dat_i,wb_dat_o,
  input wire logic first_cts_n,first_dsr_n,first_dcd_n,ir_cts_n,ir_dsr_n,ir_dcd_n
);
  logic [2:0] p0,p1;
  logic [1:0] en;
  logic tk,rd;
  assign p0={first_dcd_n,first_dsr_n,first_cts_n};
  assign p1={ir_dcd_n,ir_dsr_n,ir_cts_n};
  assign tk=wb_cyc_i&&wb_stb_i&&!wb_ack_o;
  assign rd=tk&&!wb_we_i&&wb_adr_i[1:0]==2'h0&&!wb_adr_i[2];
  // enable mirror, so irq checks need no peek inside
  always_ff @(posedge clk or posedge rst)
    if (rst) en<=2'h0;
    else if (tk&&wb_we_i&&wb_sel_i[0]&&wb_adr_i[2:0]==3'h4) en[wb_adr_i[3]]<=wb_dat_i[0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_r0;rd&&!wb_adr_i[3]&&!$past(rst,3)|=>{wb_dat_o[7],wb_dat_o[5:4]}==~$past(p0,4);endproperty
  a_r0: assert property(p_r0) else $error("ch0 levels");
  property p_r1;rd&&wb_adr_i[3]&&!$past(rst,3)|=>{wb_dat_o[7],wb_dat_o[5:4]}==~$past(p1,4);endproperty
  a_r1: assert property(p_r1) else $error("ch1 levels");
  property p_cts;en[0]&&$changed(first_cts_n)|->##3(first_irq||!en[0]);endproperty
  a_cts: assert property(p_cts) else $error("cts irq");
  property p_dsr;en[0]&&$changed(first_dsr_n)|->##3(first_irq||!en[0]);endproperty
  a_dsr: assert property(p_dsr) else $error("dsr irq");
  property p_dcd;en[0]&&$changed(first_dcd_n)|->##3(first_irq||!en[0]);endproperty
  a_dcd: assert property(p_dcd) else $error("dcd irq");
  property p_ir;en[1]&&$changed(p1)|->##3(ir_irq||!en[1]);endproperty
  a_ir: assert property(p_ir) else $error("ch1 irq");
  property p_en;(en[0]||!first_irq)&&(en[1]||!ir_irq);endproperty
  a_en: assert property(p_en) else $error("irq while disabled");
  // pins quiet long enough that no flag can be re-set by the read
  property p_clr;rd&&!wb_adr_i[3]&&!$past(rst,3)&&$stable(p0)&&$past(p0)==$past(p0,2)
    &&$past(p0,2)==$past(p0,3)|=>!first_irq;endproperty
  a_clr: assert property(p_clr) else $error("flags kept");
endmodule : msi_monitor

//--- tb/msi_modem.sv
`timescale 1ns/1ns
// modem lines idle high, each toggled on command
module msi_modem (
  input wire logic clk,rst,
  input wire logic [5:0] flip,
  output logic [5:0] pins_n
);
  always_ff @(posedge clk or posedge rst)
    if (rst) pins_n<=6'h3F;
    else pins_n<=pins_n^flip;
endmodule : msi_modem

//--- tb/msi_top_tb_top.sv
`timescale 1ns/1ns
`define CHK(n,e,s) begin compares++; if ((s)!==(e)) begin n_mismatch++; $display("wrong value %s exp %h got %h",n,e,s); end end
module msi_top_tb_top;
  logic clk=0,rst=1,cyc=0,we=0,ack;
  logic [3:0] adr=0;
  logic [31:0] wd=0,rd;
  logic [5:0] f=0,pn;
  logic [1:0] irq,en;
  logic [2:0] c[2]='{3'h0,3'h0};
  logic [7:0] lf=8'h51;
  int n_mismatch=0,compares=0,i,k;
  always #5 clk=~clk;
  msi_modem msi_modem_i(.clk(clk),.rst(rst),.flip(f),.pins_n(pn));
  msi_top msi_top_i(.clk(clk),.rst(rst),.wb_cyc_i(cyc),.wb_stb_i(cyc),.wb_we_i(we),
    .wb_adr_i(adr),.wb_sel_i(4'hF),.wb_dat_i(wd),.wb_dat_o(rd),.wb_ack_o(ack),
    .first_cts_n(pn[0]),.first_dsr_n(pn[1]),.first_dcd_n(pn[2]),.ir_cts_n(pn[3]),
    .ir_dsr_n(pn[4]),.ir_dcd_n(pn[5]),.first_irq(irq[0]),.ir_irq(irq[1]));
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d",n_mismatch,compares);
    if (n_mismatch==0&&compares>0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w,input logic [3:0] a,input logic [31:0] d);
    @(posedge clk) {cyc,we,adr,wd}<={1'h1,w,a,d};
    for (k=0;k<9&&ack!==1'h1;k++) @(posedge clk);
    if (k==9) begin n_mismatch++; tally_and_finish; end
    cyc<=0;
  endtask : bus
  function automatic logic [31:0] st(logic [2:0] q,logic [2:0] g);
    return {24'h0,~q[2],1'h0,~q[1:0],g[2],1'h0,g[1:0]};
  endfunction : st
  // random pin flips and enables, then each status read twice
  initial begin
    repeat (5) @(posedge clk);
    rst<=0;
    bus(0,4'h2,0); `CHK("unmapped",32'h0,rd)
    repeat (30) begin
      lf={lf[6:0],lf[7]^lf[5]^lf[4]^lf[3]};
      en=lf[7:6];
      bus(1,msi_pkg::ENABLE0_ADDR,{31'h0,en[0]});
      bus(1,msi_pkg::ENABLE1_ADDR,{31'h0,en[1]});
      @(posedge clk) f<=lf[5:0];
      @(posedge clk) f<=0;
      c[0]|=lf[2:0];
      c[1]|=lf[5:3];
      repeat (5) @(posedge clk);
      `CHK("irq",{en[1]&&c[1]!=0,en[0]&&c[0]!=0},irq)
      for (i=0;i<4;i++) begin
        bus(0,i[0]?msi_pkg::STATUS1_ADDR:msi_pkg::STATUS0_ADDR,0);
        `CHK("status",st(i[0]?pn[5:3]:pn[2:0],c[i[0]]),rd)
        c[i[0]]=0;
      end
      `CHK("irq after read",2'h0,irq)
    end
    tally_and_finish;
  end
endmodule : msi_top_tb_top
bind msi_top msi_monitor msi_monitor_i(.*);
